// File: input_function_decoder.sv
// multifunction digital input decoder with avalon-mm register slave
//
// Function
// R1 - an input carrying code zero never causes any action
// R2 - software sets every unused input to code zero
// R3 - codes one to four form a speed index over sixteen frequencies
// R4 - code one is index bit zero, code four is bit three
// R5 - codes five and six select one of four ramp time pairs
// R6 - any input carrying code seven selects three-wire start control
// R7 - active code eight blocks the output at once for coasting
// R8 - codes nine and ten raise and lower set frequency at configured rate
// R9 - active code eleven clears the up/down frequency to zero
// R10 - code thirteen enters dc braking at brake frequency while stopping
// R11 - code fourteen swaps panel and input command source when those selected
// R12 - logic control runs only with nonzero program and code fifteen off
// R13 - code sixteen pauses logic control at zero speed, resumes afterwards
// R14 - code seventeen picks torque control in mode zero; mode one always torque
// R15 - code eighteen swaps channel a and current term for combinations 0,2,3,5
// R16 - code nineteen closed or twenty open raises latched external stop alarm
// R17 - code twenty-one performs an error reset like the panel reset
// R18 - code twenty-two switches panel or input command source to communication
// R19 - in speed mode code twenty-three takes torque limit from channel a
// R20 - in speed mode code twenty-four takes torque limit from channel b
// R21 - code twenty-five enables forward jogging
// R22 - code twenty-six enables reverse jogging
// R23 - eight inputs decoded, each with its own freely assigned code
// R24 - every input is synchronised and debounced before decoding
// R25 - a code shared by several inputs is active when any is active
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module input_function_decoder
  import input_function_pkg::*;
#(
  parameter int NUM_INPUTS    = 8,
  parameter int DEBOUNCE_LEN  = DEBOUNCE_CYCLES,
  parameter int STEP_DIVISOR  = CLOCK_HZ
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // terminals and drive state
  input  wire logic [7:0]  multifunction_input_in,
  input  wire logic        decel_to_stop_in,
  input  wire logic        at_brake_freq_in,
  // decoded drive actions
  output logic      [3:0]  speed_index_out,
  output logic      [1:0]  ramp_set_out,
  output logic             three_wire_mode_out,
  output logic             coast_stop_out,
  output logic      [15:0] updown_freq_out,
  output logic             dc_brake_now_out,
  output logic      [1:0]  command_source_out,
  output logic             logic_run_out,
  output logic             zero_speed_out,
  output logic             torque_mode_out,
  output logic             analog_swap_out,
  output logic             torque_limit_a_out,
  output logic             torque_limit_b_out,
  output logic             external_stop_alarm_out,
  output logic             error_reset_out,
  output logic             jog_forward_out,
  output logic             jog_reverse_out
);
  localparam int CW = $clog2(DEBOUNCE_LEN + 1);
  localparam int FW = $clog2(STEP_DIVISOR) + 1;

  if (NUM_INPUTS != 8 || DEBOUNCE_LEN < 2 || STEP_DIVISOR <= 16383) begin : g_bad_params
    $error("input_function_decoder: unsupported parameter values");
  end

  typedef struct packed {
    logic [7:0]          sync1, sync2, stable;
    logic [7:0][CW-1:0]  cnt;
    logic [7:0][4:0]     codes;
    logic [1:0]          cmd_cfg;
    logic                mode_cfg;
    logic [2:0]          combo_cfg;
    logic [3:0]          fsrc_cfg;
    logic [7:0]          prog_cfg;
    logic [13:0]         rate;
    logic [15:0]         flimit;
    logic [FW-1:0]       frac;
    logic [15:0]         ufreq;
    logic                alarm, reset_prev, ack;
    logic [31:0]         rdata;
    logic [3:0]          speed_idx;
    logic [1:0]          ramp;
    logic                three_wire, coast, dc_brake;
    logic [1:0]          cmd_src;
    logic                logic_run, zero_speed, torque, swap;
    logic                tlim_a, tlim_b, err_reset, jog_f, jog_r;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] decode_functions(input logic [7:0] lvl, input logic [7:0][4:0] codes);
    logic [31:0] f;
    f = 32'h0;
    for (int i = 0; i < 8; i++) begin
      if (codes[i] != 5'h00 && codes[i] <= 5'(FN_LAST)) begin                // see R1 see R23
        f[codes[i]] = f[codes[i]] | ((codes[i] == 5'h14) ? ~lvl[i] : lvl[i]); // see R25 see R16
      end
    end
    return f;
  endfunction : decode_functions

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return m;
  endfunction : merge_bytes

  logic [31:0] fn;
  logic [31:0] cfg_word;
  logic [31:0] codes_lo;
  logic [31:0] codes_hi;
  assign fn = decode_functions(state_reg.stable, state_reg.codes);
  assign cfg_word = {8'h00, state_reg.prog_cfg, 4'h0, state_reg.fsrc_cfg, 1'b0, state_reg.combo_cfg,
                     1'b0, state_reg.mode_cfg, state_reg.cmd_cfg};
  assign codes_lo = {3'h0, state_reg.codes[3], 3'h0, state_reg.codes[2], 3'h0, state_reg.codes[1],
                     3'h0, state_reg.codes[0]};
  assign codes_hi = {3'h0, state_reg.codes[7], 3'h0, state_reg.codes[6], 3'h0, state_reg.codes[5],
                     3'h0, state_reg.codes[4]};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    logic        access;
    logic        sw_reset;
    logic        torque_now;
    logic        logic_enabled;
    w = 32'h0;
    access = (avs_read_in || avs_write_in) && !state_reg.ack;
    sw_reset = 1'b0;
    logic_enabled = (state_reg.prog_cfg != 8'h00) && !fn[15];                // see R12
    torque_now = state_reg.mode_cfg || fn[17];                               // see R14
    state_next = state_reg;

    // synchronise and debounce the terminals
    state_next.sync1 = multifunction_input_in;                               // see R24
    state_next.sync2 = state_reg.sync1;
    for (int i = 0; i < 8; i++) begin
      if (state_reg.sync2[i] != state_reg.stable[i]) begin
        if (state_reg.cnt[i] == CW'(DEBOUNCE_LEN - 1)) begin                 // see R24
          state_next.stable[i] = state_reg.sync2[i];
          state_next.cnt[i] = '0;
        end else begin
          state_next.cnt[i] = state_reg.cnt[i] + CW'(1);
        end
      end else begin
        state_next.cnt[i] = '0;
      end
    end

    // avalon slave: one wait cycle, then answer
    state_next.ack = access;
    if (access && avs_write_in) begin
      unique case (avs_address_in)
        FUNC_CODES_LO_OFFSET: begin
          w = merge_bytes(codes_lo, avs_writedata_in, avs_byteenable_in);
          for (int i = 0; i < 4; i++) begin
            state_next.codes[i] = w[8*i +: 5];
          end
        end
        FUNC_CODES_HI_OFFSET: begin
          w = merge_bytes(codes_hi, avs_writedata_in, avs_byteenable_in);
          for (int i = 0; i < 4; i++) begin
            state_next.codes[i+4] = w[8*i +: 5];
          end
        end
        DRIVE_CONFIG_OFFSET: begin
          w = merge_bytes(cfg_word, avs_writedata_in, avs_byteenable_in);
          state_next.cmd_cfg = w[CFG_CMD_SRC_POS +: 2];
          state_next.mode_cfg = w[CFG_CTRL_MODE_POS];
          state_next.combo_cfg = w[CFG_COMBO_POS +: 3];
          state_next.fsrc_cfg = w[CFG_FREQ_SRC_POS +: 4];
          state_next.prog_cfg = w[CFG_LOGIC_PROG_POS +: 8];
        end
        UPDOWN_RATE_OFFSET: begin
          w = merge_bytes({18'h0, state_reg.rate}, avs_writedata_in, avs_byteenable_in);
          state_next.rate = w[13:0];
        end
        FREQ_LIMIT_OFFSET: begin
          w = merge_bytes({16'h0, state_reg.flimit}, avs_writedata_in, avs_byteenable_in);
          state_next.flimit = w[15:0];
        end
        COMMAND_OFFSET: begin
          sw_reset = avs_byteenable_in[0] && avs_writedata_in[CMD_ERR_RESET_POS];
        end
        default: ;
      endcase
    end
    if (access && avs_read_in) begin
      unique case (avs_address_in)
        FUNC_CODES_LO_OFFSET: state_next.rdata = codes_lo;
        FUNC_CODES_HI_OFFSET: state_next.rdata = codes_hi;
        DRIVE_CONFIG_OFFSET:  state_next.rdata = cfg_word;
        UPDOWN_RATE_OFFSET:   state_next.rdata = {18'h0, state_reg.rate};
        FREQ_LIMIT_OFFSET:    state_next.rdata = {16'h0, state_reg.flimit};
        DECODE_STATUS_OFFSET: state_next.rdata = {18'h0, state_reg.three_wire, state_reg.logic_run,
                                                  state_reg.torque, state_reg.cmd_src, state_reg.alarm,
                                                  state_reg.stable};
        UPDOWN_FREQ_OFFSET:   state_next.rdata = {16'h0, state_reg.ufreq};
        default:              state_next.rdata = 32'h0;
      endcase
    end

    // decoded actions
    state_next.speed_idx = {fn[4], fn[3], fn[2], fn[1]};                     // see R3 see R4
    state_next.ramp = {fn[6], fn[5]};                                        // see R5
    state_next.three_wire = fn[7] || (|{state_reg.codes[0] == 5'h07, state_reg.codes[1] == 5'h07,
                            state_reg.codes[2] == 5'h07, state_reg.codes[3] == 5'h07,
                            state_reg.codes[4] == 5'h07, state_reg.codes[5] == 5'h07,
                            state_reg.codes[6] == 5'h07, state_reg.codes[7] == 5'h07}); // see R6
    state_next.coast = fn[8];                                                // see R7
    state_next.dc_brake = decel_to_stop_in && at_brake_freq_in && fn[13];    // see R10
    state_next.cmd_src = state_reg.cmd_cfg;
    if ((state_reg.cmd_cfg == SRC_PANEL || state_reg.cmd_cfg == SRC_INPUTS) && fn[22]) begin
      state_next.cmd_src = SRC_COMM;                                         // see R18
    end else if ((state_reg.cmd_cfg == SRC_PANEL || state_reg.cmd_cfg == SRC_INPUTS) && fn[14]) begin
      state_next.cmd_src = (state_reg.cmd_cfg == SRC_PANEL) ? SRC_INPUTS : SRC_PANEL; // see R11
    end
    state_next.logic_run = logic_enabled && !fn[16];                         // see R13
    state_next.zero_speed = logic_enabled && fn[16];                         // see R13
    state_next.torque = torque_now;
    state_next.swap = fn[18] && (state_reg.fsrc_cfg == FREQ_SRC_ANALOG)
                      && (state_reg.combo_cfg == 3'h0 || state_reg.combo_cfg == 3'h2
                          || state_reg.combo_cfg == 3'h3 || state_reg.combo_cfg == 3'h5); // see R15
    state_next.tlim_a = !torque_now && fn[23];                               // see R19
    state_next.tlim_b = !torque_now && fn[24];                               // see R20
    state_next.jog_f = fn[25];                                               // see R21
    state_next.jog_r = fn[26];                                               // see R22

    // error reset and latched alarm, a new error wins over the reset
    state_next.reset_prev = fn[21];
    state_next.err_reset = (fn[21] && !state_reg.reset_prev) || sw_reset;    // see R17
    if (fn[19] || fn[20]) begin
      state_next.alarm = 1'b1;                                               // see R16
    end else if (state_reg.err_reset) begin
      state_next.alarm = 1'b0;
    end

    // up/down frequency trim in 0.01 hz steps
    if (fn[11]) begin
      state_next.ufreq = 16'h0;                                              // see R9
      state_next.frac = '0;
    end else if (fn[9] != fn[10]) begin
      if (state_reg.frac + FW'(state_reg.rate) >= FW'(STEP_DIVISOR)) begin   // see R8
        state_next.frac = state_reg.frac + FW'(state_reg.rate) - FW'(STEP_DIVISOR);
        if (fn[9] && state_reg.ufreq < state_reg.flimit) begin
          state_next.ufreq = state_reg.ufreq + 16'h1;
        end else if (fn[10] && state_reg.ufreq != 16'h0) begin
          state_next.ufreq = state_reg.ufreq - 16'h1;
        end
      end else begin
        state_next.frac = state_reg.frac + FW'(state_reg.rate);
      end
    end
    if (state_next.ufreq > state_reg.flimit) begin
      state_next.ufreq = state_reg.flimit;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
      state_reg.codes <= {8{FUNC_CODE_RESET}};
      state_reg.rate <= UPDOWN_RATE_RESET;
      state_reg.flimit <= FREQ_LIMIT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign avs_waitrequest_out     = (avs_read_in || avs_write_in) && !state_reg.ack;
  assign avs_readdata_out        = state_reg.rdata;
  assign speed_index_out         = state_reg.speed_idx;
  assign ramp_set_out            = state_reg.ramp;
  assign three_wire_mode_out     = state_reg.three_wire;
  assign coast_stop_out          = state_reg.coast;
  assign updown_freq_out         = state_reg.ufreq;
  assign dc_brake_now_out        = state_reg.dc_brake;
  assign command_source_out      = state_reg.cmd_src;
  assign logic_run_out           = state_reg.logic_run;
  assign zero_speed_out          = state_reg.zero_speed;
  assign torque_mode_out         = state_reg.torque;
  assign analog_swap_out         = state_reg.swap;
  assign torque_limit_a_out      = state_reg.tlim_a;
  assign torque_limit_b_out      = state_reg.tlim_b;
  assign external_stop_alarm_out = state_reg.alarm;
  assign error_reset_out         = state_reg.err_reset;
  assign jog_forward_out         = state_reg.jog_f;
  assign jog_reverse_out         = state_reg.jog_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  property p_code_zero_idle;
    (state_reg.codes == '0) |=> (!coast_stop_out && speed_index_out == 4'h0 && !jog_forward_out);
  endproperty
  a_code_zero_idle: assert property (p_code_zero_idle) else $error("code zero caused an action"); // see R1
  property p_speed_index;
    1'b1 |=> speed_index_out == $past({fn[4], fn[3], fn[2], fn[1]});
  endproperty
  a_speed_index: assert property (p_speed_index) else $error("speed index bit order wrong"); // see R3 see R4
  property p_ramp_set;
    1'b1 |=> ramp_set_out == $past({fn[6], fn[5]});
  endproperty
  a_ramp_set: assert property (p_ramp_set) else $error("ramp set index wrong"); // see R5
  property p_coast;
    fn[8] |=> coast_stop_out;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop not asserted"); // see R7
  property p_clear_freq;
    fn[11] |=> updown_freq_out == 16'h0;
  endproperty
  a_clear_freq: assert property (p_clear_freq) else $error("up/down frequency not cleared"); // see R9
  property p_updown_step;
    1'b1 |=> $past(fn[11]) || ({1'b0, updown_freq_out} <= {1'b0, $past(updown_freq_out)} + 17'h1
             && ($past(fn[9] ^ fn[10]) || updown_freq_out <= $past(updown_freq_out)));
  endproperty
  a_updown_step: assert property (p_updown_step) else $error("up/down frequency moved wrongly"); // see R8
  property p_alarm;
    (fn[19] || fn[20]) |=> external_stop_alarm_out ##1 external_stop_alarm_out;
  endproperty
  a_alarm: assert property (p_alarm) else $error("external stop alarm not latched"); // see R16
  property p_logic_run;
    1'b1 |=> logic_run_out == ($past(state_reg.prog_cfg) != 8'h00 && !$past(fn[15]) && !$past(fn[16]));
  endproperty
  a_logic_run: assert property (p_logic_run) else $error("logic control state wrong"); // see R12 see R13
  property p_torque_limit;
    torque_mode_out |-> !torque_limit_a_out && !torque_limit_b_out;
  endproperty
  a_torque_limit: assert property (p_torque_limit) else $error("torque limit enabled in torque mode"); // see R19 see R20
  property p_bus_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered in one wait cycle");
endmodule : input_function_decoder

// File: input_function_pkg.sv
// constants shared by the multifunction input decoder
package input_function_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [4:0] FUNC_CODES_LO_OFFSET = 5'h00;
  localparam logic [4:0] FUNC_CODES_HI_OFFSET = 5'h04;
  localparam logic [4:0] DRIVE_CONFIG_OFFSET  = 5'h08;
  localparam logic [4:0] UPDOWN_RATE_OFFSET   = 5'h0c;
  localparam logic [4:0] FREQ_LIMIT_OFFSET    = 5'h10;
  localparam logic [4:0] DECODE_STATUS_OFFSET = 5'h14;
  localparam logic [4:0] UPDOWN_FREQ_OFFSET   = 5'h18;
  localparam logic [4:0] COMMAND_OFFSET       = 5'h1c;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_CMD_SRC_POS = 0;
  localparam int CFG_CTRL_MODE_POS = 2;
  localparam int CFG_COMBO_POS = 4;
  localparam int CFG_FREQ_SRC_POS = 8;
  localparam int CFG_LOGIC_PROG_POS = 16;
  localparam int CMD_ERR_RESET_POS = 0;
  localparam int STAT_ALARM_POS = 8;
  localparam int STAT_CMD_SRC_POS = 9;
  localparam int STAT_TORQUE_POS = 11;
  localparam int STAT_LOGIC_RUN_POS = 12;
  localparam int STAT_THREE_WIRE_POS = 13;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [4:0]  FUNC_CODE_RESET   = 5'h00;
  localparam logic [13:0] UPDOWN_RATE_RESET = 14'h0008;
  localparam logic [15:0] FREQ_LIMIT_RESET  = 16'h1388;
  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] SRC_PANEL  = 2'h0;
  localparam logic [1:0] SRC_INPUTS = 2'h1;
  localparam logic [1:0] SRC_COMM   = 2'h2;
  localparam logic [3:0] FREQ_SRC_ANALOG = 4'h2;
  localparam int FN_LAST = 29;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLOCK_HZ = 50000000;
  localparam int DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLOCK_HZ / 1000000);
endpackage : input_function_pkg

// File: terminal_switch_model.sv
// switch contacts wired to the eight multifunction terminals
`timescale 1ns/10ps
module terminal_switch_model (
  // clock
  input  wire logic       clock_in,
  // commanded contact levels and a contact bounce mask, held while set
  input  wire logic [7:0] level_in,
  input  wire logic [7:0] bounce_in,
  // terminal levels, closed contact reads high
  output logic      [7:0] terminal_out
);
  // contacts move just after an edge; a bounce flips a contact for as long as bounce_in stays set
  always_ff @(posedge clock_in) begin
    terminal_out <= level_in ^ bounce_in;
  end
endmodule : terminal_switch_model

// File: drive_input_function_decoder_test.sv
// self-checking bench for the multifunction input decoder
`timescale 1ns/10ps
module drive_input_function_decoder_test;
  import input_function_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int          DB = 4;
  localparam logic [11:0] BASE = 12'h200;
  localparam logic [4:0]  CODES [13] = '{5'h00, 5'h08, 5'h0d, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h17, 5'h18, 5'h19,
                                         5'h1a, 5'h0e, 5'h16};
  localparam logic [11:0] EXP [13] = '{12'h200, 12'ha00, 12'h600, 12'h000, 12'h100, 12'h280, 12'h240, 12'h220,
                                       12'h210, 12'h208, 12'h204, 12'h201, 12'h202};
  logic        clock_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out, decel_to_stop_in;
  logic        at_brake_freq_in, three_wire_mode_out, coast_stop_out, dc_brake_now_out, logic_run_out;
  logic        zero_speed_out, torque_mode_out, analog_swap_out, torque_limit_a_out, torque_limit_b_out;
  logic        external_stop_alarm_out, error_reset_out, jog_forward_out, jog_reverse_out;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [3:0]  avs_byteenable_in, speed_index_out;
  logic [1:0]  ramp_set_out, command_source_out;
  logic [15:0] updown_freq_out;
  logic [7:0]  multifunction_input_in, level, bounce;
  logic [11:0] acts;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_resets = 0;
  assign acts = {coast_stop_out, dc_brake_now_out, logic_run_out, zero_speed_out, torque_mode_out, analog_swap_out,
                 torque_limit_a_out, torque_limit_b_out, jog_forward_out, jog_reverse_out, command_source_out};
  input_function_decoder #(.DEBOUNCE_LEN(DB), .STEP_DIVISOR(16384)) uut (
    .clock_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .multifunction_input_in, .decel_to_stop_in, .at_brake_freq_in,
    .speed_index_out, .ramp_set_out, .three_wire_mode_out, .coast_stop_out, .updown_freq_out, .dc_brake_now_out,
    .command_source_out, .logic_run_out, .zero_speed_out, .torque_mode_out, .analog_swap_out, .torque_limit_a_out,
    .torque_limit_b_out, .external_stop_alarm_out, .error_reset_out, .jog_forward_out, .jog_reverse_out);
  terminal_switch_model sw (.clock_in, .level_in(level), .bounce_in(bounce), .terminal_out(multifunction_input_in));
  // one-cycle reset pulses, counted as they stand at each edge
  always @(posedge clock_in)
    if (error_reset_out === 1'b1)
      n_resets <= n_resets + 1;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one avalon transfer; entered just after an edge, leaves one edge after release
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    n = 0;
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    if (avs_waitrequest_out !== 1'b0) begin
      n_mismatch++;
      test_done();
    end
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus
  // move the contacts and wait past synchroniser and debounce
  task set_lv(input logic [7:0] v);
    level <= v;
    repeat (DB + 8) @(posedge clock_in);
  endtask : set_lv
  // ------------------------------------------------------------
  // clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'h0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    n_mismatch++;
    test_done();
  end
  initial begin
    {nrst_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, level, bounce} = '0;
    {decel_to_stop_in, at_brake_freq_in, avs_byteenable_in} = 6'h3f;
    repeat (5) @(posedge clock_in);
    nrst_in <= 1'h1;
    @(posedge clock_in);
    bus(1'h0, UPDOWN_RATE_OFFSET, 32'h0);
    check("rate_reset", {18'h0, UPDOWN_RATE_RESET}, rd);
    bus(1'h0, FREQ_LIMIT_OFFSET, 32'h0);
    check("limit_reset", {16'h0, FREQ_LIMIT_RESET}, rd);
    bus(1'h1, UPDOWN_RATE_OFFSET, 32'h3fff);
    bus(1'h1, FREQ_LIMIT_OFFSET, 32'h10);
    bus(1'h0, UPDOWN_RATE_OFFSET, 32'h0);
    check("rate_rw", 32'h3fff, rd);
    $display("test registers done");
    bus(1'h1, FUNC_CODES_LO_OFFSET, 32'h04030201);
    bus(1'h1, FUNC_CODES_HI_OFFSET, 32'h07080605);
    check("three_wire", 32'h1, three_wire_mode_out);
    for (int i = 0; i < 16; i++) begin
      set_lv(8'(i));
      check("speed_index", i, speed_index_out);
    end
    for (int i = 0; i < 4; i++) begin
      set_lv(8'(i << 4));
      check("ramp_set", i, ramp_set_out);
    end
    set_lv(8'h40);
    check("coast", 32'h1, coast_stop_out);
    set_lv(8'h00);
    bounce <= 8'h0f;
    @(posedge clock_in);
    bounce <= 8'h00;
    set_lv(8'h00);
    check("glitch", 32'h0, speed_index_out);
    $display("test multispeed done");
    bus(1'h1, FUNC_CODES_HI_OFFSET, 32'h0);
    bus(1'h1, DRIVE_CONFIG_OFFSET, 32'h00010200);
    for (int k = 0; k < 13; k++) begin
      bus(1'h1, FUNC_CODES_LO_OFFSET, {27'h0, CODES[k]});
      set_lv(8'h00);
      check("idle_actions", BASE, acts);
      set_lv(8'h01);
      check("actions", EXP[k], acts);
    end
    bus(1'h1, FUNC_CODES_LO_OFFSET, 32'h0d);
    at_brake_freq_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    check("brake_not_at_freq", BASE, acts);
    at_brake_freq_in <= 1'b1;
    bus(1'h1, DRIVE_CONFIG_OFFSET, 32'h00010204);
    bus(1'h1, FUNC_CODES_LO_OFFSET, 32'h17);
    check("torque_mode1", 12'h280, acts);
    bus(1'h1, DRIVE_CONFIG_OFFSET, 32'h00010210);
    bus(1'h1, FUNC_CODES_LO_OFFSET, 32'h12);
    check("swap_combo1", BASE, acts);
    $display("test functions done");
    set_lv(8'h08);
    bus(1'h1, FUNC_CODES_LO_OFFSET, 32'h14151313);
    bus(1'h1, COMMAND_OFFSET, 32'h1);
    set_lv(8'h08);
    check("alarm_idle", 32'h0, external_stop_alarm_out);
    set_lv(8'h0a);
    check("alarm_no", 32'h1, external_stop_alarm_out);
    bus(1'h0, DECODE_STATUS_OFFSET, 32'h0);
    check("status", 32'h110a, rd);
    set_lv(8'h0c);
    set_lv(8'h08);
    check("alarm_reset", 32'h0, external_stop_alarm_out);
    set_lv(8'h00);
    check("alarm_nc", 32'h1, external_stop_alarm_out);
    set_lv(8'h08);
    bus(1'h1, COMMAND_OFFSET, 32'h1);
    set_lv(8'h08);
    check("alarm_cmd", 32'h0, external_stop_alarm_out);
    check("reset_pulses", 32'h3, n_resets);
    $display("test alarm done");
    bus(1'h1, FUNC_CODES_LO_OFFSET, 32'h000b0a09);
    set_lv(8'h01);
    repeat (40) @(posedge clock_in);
    check("up_limit", 32'h10, updown_freq_out);
    bus(1'h0, UPDOWN_FREQ_OFFSET, 32'h0);
    check("up_reg", 32'h10, rd);
    set_lv(8'h05);
    check("clear", 32'h0, updown_freq_out);
    set_lv(8'h01);
    set_lv(8'h02);
    repeat (40) @(posedge clock_in);
    check("down_floor", 32'h0, updown_freq_out);
    $display("test updown done");
    test_done();
  end
endmodule : drive_input_function_decoder_test
